// ---- vectored_irq_controller_regs.v ----
// Register interface and line logic of the 32-source vectored interrupt unit
//
// The Avalon-MM slave port and the register offsets were decided locally.
`timescale 1ns/100ps
`include "vic_defines.vh"

module vectored_irq_controller_regs #(
	parameter NSRC = 32
) (
	input  wire        clk,
	input  wire        sys_rst,
	input  wire [9:0]  address,
	input  wire        read,
	input  wire        write,
	input  wire [31:0] writedata,
	input  wire [3:0]  byteenable,
	output reg  [31:0] readdata,
	output reg         waitrequest,
	input  wire [31:0] source_in,
	output reg         fast_request_out_n,
	output reg         normal_request_out_n
);

	// ==========================================================
	// Helpers
	function [31:0] lane_mask;
		input [3:0] be;
		begin
			lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		end
	endfunction

	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0]  be;
		begin
			merge = (old & ~lane_mask(be)) | (nw & lane_mask(be));
		end
	endfunction

	// ==========================================================
	// Storage
	reg  [31:0] vect_table [0:NSRC-1];
	reg  [2:0]  prio_q     [0:NSRC-1];
	reg  [31:0] pending_q;
	reg  [31:0] mask_q;
	reg  [31:0] spurious_handler_address;
	reg         global_output_mask;
	reg         cur_valid_q;
	reg  [4:0]  current_source_number;
	reg  [31:0] src_s1_q;
	reg  [31:0] src_s2_q;
	reg  [31:0] src_s3_q;
	reg  [31:0] src_level_q;
	integer     i;

	// ==========================================================
	// Source synchroniser, rising edge once stages two and three agree
	wire [31:0] agree    = ~(src_s2_q ^ src_s3_q);
	wire [31:0] src_rise = agree & src_s3_q & ~src_level_q;

	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			src_s1_q    <= `VIC_RESET_WORD;
			src_s2_q    <= `VIC_RESET_WORD;
			src_s3_q    <= `VIC_RESET_WORD;
			src_level_q <= `VIC_RESET_WORD;
		end else begin
			src_s1_q    <= source_in;
			src_s2_q    <= src_s1_q;
			src_s3_q    <= src_s2_q;
			src_level_q <= (agree & src_s3_q) | (~agree & src_level_q);
		end
	end

	// ==========================================================
	// Arbitration among enabled non-fast sources
	wire [31:0] active = pending_q & mask_q;
	reg         best_found;
	reg  [4:0]  best_id;
	reg  [2:0]  best_prio;

	always @* begin
		best_found = 1'b0;
		best_id    = 5'h00;
		best_prio  = 3'h0;
		for (i = 1; i < NSRC; i = i + 1) begin
			if (active[i] && (!best_found || prio_q[i] > best_prio)) begin
				best_found = 1'b1;
				best_id    = i[4:0];
				best_prio  = prio_q[i];
			end
		end
	end

	// ==========================================================
	// Bus decode
	wire        req       = (read || write) && waitrequest;
	wire        wr_hit    = req && write;
	wire        rd_hit    = req && read && !write;
	wire        in_mode   = (address < `VIC_VECT_BASE);
	wire        in_vect   = (address >= `VIC_VECT_BASE) && (address < `VIC_NORMAL_VEC);
	wire [4:0]  tbl_idx   = address[6:2];
	wire [31:0] wmask     = writedata & lane_mask(byteenable);
	wire        rd_normal = rd_hit && (address == `VIC_NORMAL_VEC);
	wire        rd_fast   = rd_hit && (address == `VIC_FAST_VEC);
	wire        fast_live = active[`VIC_FAST_SRC];

	// Pending bits taken by a vector read
	reg  [31:0] taken;
	always @* begin
		taken = `VIC_RESET_WORD;
		if (rd_normal && best_found)
			taken[best_id] = 1'b1;
		if (rd_fast && fast_live)
			taken[`VIC_FAST_SRC] = 1'b1;
	end

	reg  [31:0] rd_word;
	always @* begin
		rd_word = `VIC_RESET_WORD;
		if (in_mode)
			rd_word[`VIC_PRIO_MSB:0] = prio_q[tbl_idx];
		else if (in_vect)
			rd_word = vect_table[tbl_idx];
		else begin
			case (address)
				`VIC_NORMAL_VEC:  rd_word = best_found ? vect_table[best_id] : spurious_handler_address;
				`VIC_FAST_VEC:    rd_word = fast_live ? vect_table[`VIC_FAST_SRC] : spurious_handler_address;
				`VIC_CUR_STATUS:  rd_word = {27'h0000000, current_source_number};
				`VIC_PENDING:     rd_word = pending_q;
				`VIC_MASK:        rd_word = mask_q;
				`VIC_LINE_STATUS: rd_word = {30'h00000000, ~normal_request_out_n, ~fast_request_out_n};
				`VIC_SPURIOUS:    rd_word = spurious_handler_address;
				`VIC_DEBUG_CTRL:  rd_word = {30'h00000000, global_output_mask, 1'b0};
				default:          rd_word = `VIC_RESET_WORD;
			endcase
		end
	end

	// ==========================================================
	// Bus handshake, one wait cycle per access
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			waitrequest <= 1'b1;
			readdata    <= `VIC_RESET_WORD;
		end else if (req) begin
			waitrequest <= 1'b0;
			readdata    <= rd_hit ? rd_word : `VIC_RESET_WORD;
		end else begin
			waitrequest <= 1'b1;
		end
	end

	// ==========================================================
	// Tables and control
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (i = 0; i < NSRC; i = i + 1) begin
				vect_table[i] <= `VIC_RESET_WORD;
				prio_q[i]     <= 3'h0;
			end
			spurious_handler_address <= `VIC_RESET_WORD;
			global_output_mask       <= 1'b0;
		end else if (wr_hit) begin
			if (in_mode && tbl_idx != `VIC_FAST_SRC && byteenable[0])
				prio_q[tbl_idx] <= writedata[`VIC_PRIO_MSB:0];
			if (in_vect)
				vect_table[tbl_idx] <= merge(vect_table[tbl_idx], writedata, byteenable);
			if (address == `VIC_SPURIOUS)
				spurious_handler_address <= merge(spurious_handler_address, writedata, byteenable);
			if (address == `VIC_DEBUG_CTRL && byteenable[0])
				global_output_mask <= writedata[`VIC_GMASK_BIT];
		end
	end

	// ==========================================================
	// Mask, pending and current source
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			mask_q                <= `VIC_RESET_WORD;
			pending_q             <= `VIC_RESET_WORD;
			cur_valid_q           <= 1'b0;
			current_source_number <= 5'h00;
		end else begin
			if (wr_hit && address == `VIC_ENABLE_CMD)
				mask_q <= mask_q | wmask;
			else if (wr_hit && address == `VIC_DISABLE_CMD)
				mask_q <= mask_q & ~wmask;
			// New edges win over clear and over a vector read
			if (wr_hit && address == `VIC_CLEAR_CMD)
				pending_q <= (pending_q & ~wmask) | src_rise;
			else if (wr_hit && address == `VIC_SET_CMD)
				pending_q <= pending_q | wmask | src_rise;
			else
				pending_q <= (pending_q & ~taken) | src_rise;
			if (rd_normal && best_found) begin
				cur_valid_q           <= 1'b1;
				current_source_number <= best_id;
			end else if (wr_hit && address == `VIC_EOS_CMD) begin
				cur_valid_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Processor lines
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			fast_request_out_n   <= 1'b1;
			normal_request_out_n <= 1'b1;
		end else begin
			fast_request_out_n   <= ~(fast_live && !global_output_mask);
			normal_request_out_n <= ~(best_found && !global_output_mask);
		end
	end

endmodule // vectored_irq_controller_regs

// ---- vic_defines.vh ----
// Register map, field positions and reset values of the vectored interrupt unit
`ifndef VIC_DEFINES_VH
`define VIC_DEFINES_VH

// ==========================================================
// Offsets
`define VIC_MODE_BASE     10'h000
`define VIC_VECT_BASE     10'h080
`define VIC_NORMAL_VEC    10'h100
`define VIC_FAST_VEC      10'h104
`define VIC_CUR_STATUS    10'h108
`define VIC_PENDING       10'h10c
`define VIC_MASK          10'h110
`define VIC_LINE_STATUS   10'h114
`define VIC_ENABLE_CMD    10'h120
`define VIC_DISABLE_CMD   10'h124
`define VIC_CLEAR_CMD     10'h128
`define VIC_SET_CMD       10'h12c
`define VIC_EOS_CMD       10'h130
`define VIC_SPURIOUS      10'h134
`define VIC_DEBUG_CTRL    10'h138

// ==========================================================
// Fields and reset values
`define VIC_PRIO_MSB      2
`define VIC_GMASK_BIT     1
`define VIC_FAST_SRC      0
`define VIC_RESET_WORD    32'h0000_0000

`endif

// ---- core_model.sv ----
// Processor core model sampling the two active-low request lines
`timescale 1ns/100ps
// ==========
// Line sampling
module core_model (
	input  wire clk,
	input  wire fast_request_out_n,
	input  wire normal_request_out_n,
	output reg  fast_taken,
	output reg  normal_taken
);
	always @(posedge clk) begin
		fast_taken   <= !fast_request_out_n;
		normal_taken <= !normal_request_out_n;
	end
endmodule // core_model

// ---- vic_chk.sv ----
// Checker of bus answers and register views of the interrupt unit
`timescale 1ns/100ps
`include "vic_defines.vh"
// ==========
// Checker
module vic_chk (
	input wire        clk,
	input wire        sys_rst,
	input wire [9:0]  address,
	input wire        read,
	input wire        write,
	input wire [31:0] writedata,
	input wire [3:0]  byteenable,
	input wire [31:0] readdata,
	input wire        waitrequest,
	input wire [31:0] source_in,
	input wire        fast_request_out_n,
	input wire        normal_request_out_n
);
	reg  [31:0] spur_q;
	reg  [31:0] mask_q;
	wire [31:0] m = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};
	wire        ans = read && !waitrequest;
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			spur_q <= 32'h0;
			mask_q <= 32'h0;
		end else if (write && waitrequest) begin
			if (address == `VIC_SPURIOUS) spur_q <= (spur_q & ~m) | (writedata & m);
			if (address == `VIC_ENABLE_CMD) mask_q <= mask_q | (writedata & m);
			if (address == `VIC_DISABLE_CMD) mask_q <= mask_q & ~(writedata & m);
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	wait_one_a: assert property (!waitrequest |=> waitrequest) else $error("wait low too long");
	answer_a: assert property ((read || write) && waitrequest |=> !waitrequest) else $error("no answer");
	status_field_a: assert property (ans && address == `VIC_CUR_STATUS |-> readdata[31:5] == 27'h0)
		else $error("status upper bits set");
	line_field_a: assert property (ans && address == `VIC_LINE_STATUS |-> readdata[31:2] == 30'h0)
		else $error("line status upper bits set");
	spurious_rw_a: assert property (ans && address == `VIC_SPURIOUS |-> readdata == spur_q)
		else $error("spurious readback wrong");
	mask_view_a: assert property (ans && address == `VIC_MASK |-> readdata == mask_q)
		else $error("mask view wrong");
	lines_idle_a: assert property ($past(sys_rst) |-> fast_request_out_n && normal_request_out_n)
		else $error("line active after reset");
	unmapped_a: assert property (ans && address == 10'h118 |-> readdata == 32'h0) else $error("unmapped read not zero");
endmodule // vic_chk
bind vectored_irq_controller_regs vic_chk vic_chk_i (.clk(clk), .sys_rst(sys_rst), .address(address), .read(read),
	.write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
	.source_in(source_in), .fast_request_out_n(fast_request_out_n), .normal_request_out_n(normal_request_out_n));

// ---- testbench.sv ----
// Self-checking bench of the interrupt unit register interface
`timescale 1ns/100ps
`include "vic_defines.vh"
// ==========
// Bench
module testbench;
	reg clk = 1'b0, sys_rst = 1'b1, read = 1'b0, write = 1'b0;
	reg [9:0] address = 10'h0;
	reg [31:0] writedata = 32'h0, source_in = 32'h0;
	reg [3:0] byteenable = 4'hf;
	wire [31:0] readdata;
	wire waitrequest, fast_request_out_n, normal_request_out_n, fast_taken, normal_taken;
	integer n_mismatch = 0, tests_run = 0, cycles = 0;
	always #2 clk = ~clk;
	vectored_irq_controller_regs vectored_irq_controller_regs_i (.clk(clk), .sys_rst(sys_rst), .address(address),
		.read(read), .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .source_in(source_in), .fast_request_out_n(fast_request_out_n),
		.normal_request_out_n(normal_request_out_n));
	core_model core_model_i (.clk(clk), .fast_request_out_n(fast_request_out_n),
		.normal_request_out_n(normal_request_out_n), .fast_taken(fast_taken), .normal_taken(normal_taken));
	task end_sim; begin
		$display("mismatches %0d checks %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	end endtask
	task chk(input [31:0] seen, input [31:0] exp); begin
		tests_run = tests_run + 1;
		if (seen !== exp) begin
			n_mismatch = n_mismatch + 1;
			$display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
		end
	end endtask
	task wr(input [9:0] a, input [31:0] v); begin
		@(posedge clk); address <= a; writedata <= v; write <= 1'b1;
		@(posedge clk); while (waitrequest !== 1'b0) @(posedge clk);
		write <= 1'b0;
	end endtask
	task rdc(input [9:0] a, input [31:0] exp); begin
		@(posedge clk); address <= a; read <= 1'b1;
		@(posedge clk); while (waitrequest !== 1'b0) @(posedge clk);
		chk(readdata, exp);
		read <= 1'b0;
	end endtask
	task wline(input sel); integer i; begin
		for (i = 0; i < 20 && (sel ? fast_taken : normal_taken) !== 1'b1; i = i + 1) @(posedge clk);
	end endtask
	task t_reset; begin
		rdc(`VIC_MASK, 32'h0);
		rdc(`VIC_PENDING, 32'h0);
		rdc(`VIC_SPURIOUS, 32'h0);
		rdc(`VIC_CUR_STATUS, 32'h0);
		rdc(`VIC_LINE_STATUS, 32'h0);
		rdc(`VIC_NORMAL_VEC, 32'h0);
		rdc(10'h118, 32'h0);
	end endtask
	task t_mask; begin
		wr(`VIC_ENABLE_CMD, 32'h8000_0003); rdc(`VIC_MASK, 32'h8000_0003);
		wr(`VIC_ENABLE_CMD, 32'h0); rdc(`VIC_MASK, 32'h8000_0003);
		wr(`VIC_DISABLE_CMD, 32'h1); rdc(`VIC_MASK, 32'h8000_0002);
		wr(`VIC_MASK, 32'hffff_ffff); rdc(`VIC_MASK, 32'h8000_0002);
	end endtask
	task t_pend; begin
		wr(`VIC_SET_CMD, 32'h0000_0104); rdc(`VIC_PENDING, 32'h0000_0104);
		wr(`VIC_CLEAR_CMD, 32'h4); rdc(`VIC_PENDING, 32'h0000_0100);
	end endtask
	task t_vec; begin
		wr(`VIC_SPURIOUS, 32'hdead_0000); wr(`VIC_VECT_BASE + 10'h020, 32'h0000_0a08); wr(`VIC_VECT_BASE, 32'h0000_0f00);
		wr(`VIC_ENABLE_CMD, 32'h100); wline(1'b0); chk(normal_taken, 1'b1);
		rdc(`VIC_LINE_STATUS, 32'h2);
		rdc(`VIC_NORMAL_VEC, 32'h0000_0a08);
		rdc(`VIC_CUR_STATUS, 32'h8);
		rdc(`VIC_PENDING, 32'h0);
		wr(`VIC_EOS_CMD, 32'h1234_5678); rdc(`VIC_NORMAL_VEC, 32'hdead_0000);
	end endtask
	task t_fast; begin
		rdc(`VIC_FAST_VEC, 32'hdead_0000);
		wr(`VIC_ENABLE_CMD, 32'h1); @(posedge clk); source_in <= 32'h1;
		wline(1'b1); chk(fast_taken, 1'b1);
		rdc(`VIC_LINE_STATUS, 32'h1);
		wr(`VIC_DEBUG_CTRL, 32'h2); repeat (3) @(posedge clk); chk(fast_taken, 1'b0);
		wr(`VIC_DEBUG_CTRL, 32'h0); wline(1'b1); chk(fast_taken, 1'b1);
		rdc(`VIC_FAST_VEC, 32'h0000_0f00);
		rdc(`VIC_FAST_VEC, 32'hdead_0000);
		source_in <= 32'h0;
	end endtask
	task t_prio; begin
		wr(10'h00c, 32'h5); wr(10'h008, 32'h1); wr(10'h000, 32'h7);
		rdc(10'h000, 32'h0); rdc(10'h00c, 32'h5);
		wr(`VIC_VECT_BASE + 10'h008, 32'h0000_0b02); wr(`VIC_VECT_BASE + 10'h00c, 32'h0000_0b03);
		wr(`VIC_ENABLE_CMD, 32'hc); wr(`VIC_SET_CMD, 32'hc);
		rdc(`VIC_NORMAL_VEC, 32'h0000_0b03);
		rdc(`VIC_CUR_STATUS, 32'h3);
		rdc(`VIC_PENDING, 32'h4);
		rdc(`VIC_NORMAL_VEC, 32'h0000_0b02);
		wr(`VIC_EOS_CMD, 32'h0); wr(`VIC_DISABLE_CMD, 32'hc);
	end endtask
	always @(posedge clk) begin
		cycles = cycles + 1;
		if (cycles == 3000) begin
			n_mismatch = n_mismatch + 1;
			end_sim;
		end
	end
	initial begin
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		t_reset; t_mask; t_pend; t_vec; t_fast; t_prio;
		end_sim;
	end
endmodule // testbench
